// File: verification/mns_core_exec_properties.sv
`timescale 1ns/1ns
`default_nettype none
module mns_core_exec_properties (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        clockEnable,
  input wire logic        masterClearPinN,
  input wire logic        instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [20:0] fetchPc,
  input wire logic [7:0]  accIn,
  input wire logic [3:0]  bankSelectReg,
  input wire logic        extEnable,
  input wire logic [7:0]  fileRdData,
  input wire logic [11:0] fileAddr,
  input wire logic        fileWrEn,
  input wire logic [7:0]  fileWrData,
  input wire logic        indexedMode,
  input wire logic [7:0]  productHighByte,
  input wire logic [7:0]  productLowByte,
  input wire logic [4:0]  flagsOut,
  input wire logic        flagsWrEn,
  input wire logic        pcLoad,
  input wire logic [20:0] pcTarget,
  input wire logic [20:0] stackTopEntry,
  input wire logic        fetchStall
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Bubble cycle words are not taken
  wire logic        take    = clockEnable && instrValid && masterClearPinN && !fetchStall;
  wire logic        isMul   = take && instrWord[15:9] == mns_pkg::OP_MUL_HI7;
  wire logic        isNeg   = take && instrWord[15:9] == mns_pkg::OP_NEG_HI7;
  wire logic        isCall  = take && instrWord[15:11] == mns_pkg::OP_RELATIVE_SUBROUTINE_CALL_HI5;
  wire logic        isPush  = take && instrWord == mns_pkg::OP_PUSH;
  wire logic        isReset = take && instrWord == mns_pkg::OP_SWRESET;
  wire logic [15:0] mulExp  = accIn * fileRdData;
  wire logic [7:0]  negExp  = ~fileRdData + 8'h01;
  wire logic [20:0] callExp = fetchPc + 21'h000002 + {{9{instrWord[10]}}, instrWord[10:0], 1'b0};

  chk_mul_product: assert property (
    isMul |=> {productHighByte, productLowByte} == $past(mulExp) && !flagsWrEn && !fileWrEn)
    else $error("multiply result wrong");
  chk_bank_select: assert property (
    isMul && instrWord[8] |=> fileAddr == {$past(bankSelectReg), $past(instrWord[7:0])})
    else $error("banked address wrong");
  chk_index_mode: assert property (
    (isMul || isNeg) && !instrWord[8]
    |=> indexedMode == $past(extEnable && instrWord[7:0] <= mns_pkg::IDX_LIMIT))
    else $error("indexed mode wrong");
  chk_neg_write: assert property (isNeg |=> fileWrEn && fileWrData == $past(negExp))
    else $error("negate result wrong");
  chk_neg_flags: assert property (
    isNeg |=> flagsWrEn && flagsOut[mns_pkg::FLAG_N] == $past(negExp[7])
      && flagsOut[mns_pkg::FLAG_Z] == ($past(negExp) == 8'h00))
    else $error("negate flags wrong");
  chk_call_jump: assert property (
    isCall |=> pcLoad && fetchStall && pcTarget == $past(callExp))
    else $error("call target wrong");
  chk_call_return: assert property (
    isCall ##1 clockEnable |=> stackTopEntry == $past(fetchPc, 2) + 21'h000002)
    else $error("call return address wrong");
  chk_push_top: assert property (
    isPush ##1 clockEnable |=> stackTopEntry == $past(fetchPc, 2) + 21'h000002)
    else $error("pushed address wrong");
  chk_soft_reset: assert property (
    isReset |=> pcLoad && pcTarget == 21'h000000 && flagsWrEn && flagsOut == 5'h00
      && {productHighByte, productLowByte} == 16'h0000)
    else $error("soft reset incomplete");
  cover property (isCall ##1 clockEnable);
  cover property (isNeg);
  cover property (isReset);
endmodule : mns_core_exec_properties

bind mns_core_exec mns_core_exec_properties u_props (
  .clock, .rstn, .clockEnable, .masterClearPinN, .instrValid, .instrWord, .fetchPc,
  .accIn, .bankSelectReg, .extEnable, .fileRdData, .fileAddr, .fileWrEn, .fileWrData,
  .indexedMode, .productHighByte, .productLowByte, .flagsOut, .flagsWrEn, .pcLoad,
  .pcTarget, .stackTopEntry, .fetchStall
);
`default_nettype wire

// File: verification/mns_core_exec_test.sv
`timescale 1ns/1ns
`default_nettype none
module mns_core_exec_test;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        instrValid = 1'b0;
  logic        clockEnable = 1'b1;
  logic        masterClearPinN = 1'b1;
  logic        extEnable = 1'b0;
  logic [3:0]  bankSelectReg = 4'h0;
  logic [7:0]  accIn = 8'h00;
  logic [7:0]  fileRdData = 8'h00;
  logic [15:0] instrWord = 16'h0000;
  logic [20:0] fetchPc = 21'h000000;
  logic [11:0] fileAddr;
  logic [7:0]  fileWrData, productHighByte, productLowByte, d, r;
  logic [4:0]  flagsOut, stackDepth;
  logic [20:0] pcTarget, stackTopEntry;
  logic        fileWrEn, indexedMode, flagsWrEn, pcLoad, fetchStall, softResetPulse, idleOp;
  logic [7:0]  negIn [4] = '{8'h3a, 8'h00, 8'h80, 8'h01};
  logic [10:0] callOff [3] = '{11'h7ff, 11'h3ff, 11'h400};
  logic [20:0] callJump [3] = '{21'h001000, 21'h001800, 21'h000802};
  int          errors = 0;
  int          cmp_count = 0;

  always #2 clock = ~clock;

  mns_core_exec dut (
    .clock, .rstn, .clockEnable, .masterClearPinN, .instrValid, .instrWord,
    .fetchPc, .accIn, .flagsIn(5'h00), .bankSelectReg, .extEnable, .indexBase(8'h40),
    .fileRdData, .fileAddr, .fileWrEn, .fileWrData, .indexedMode, .productHighByte,
    .productLowByte, .flagsOut, .flagsWrEn, .pcLoad, .pcTarget, .stackTopEntry,
    .stackDepth, .fetchStall, .softResetPulse, .idleOp
  );

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic put(input logic [15:0] w, input logic [20:0] pc, input logic [7:0] a,
                     input logic [7:0] o);
    @(posedge clock);
    instrValid <= 1'b1;
    instrWord  <= w;
    fetchPc    <= pc;
    accIn      <= a;
    fileRdData <= o;
  endtask : put
  task automatic done;
    @(posedge clock);
    instrValid <= 1'b0;
    #1;
  endtask : done
  task automatic op(input logic [15:0] w, input logic [20:0] pc, input logic [7:0] a,
                    input logic [7:0] o);
    put(w, pc, a, o);
    done();
  endtask : op
  task automatic cfg(input logic [3:0] b, input logic e);
    @(posedge clock);
    bankSelectReg <= b;
    extEnable     <= e;
  endtask : cfg
  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wrap_up;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    op(16'h03b5, 21'h0, 8'hc4, 8'hb5);
    cmp({fileWrEn, flagsWrEn, productHighByte, productLowByte}, 18'h08a94);
    op(16'h02ff, 21'h0, 8'hff, 8'hff);
    cmp({productHighByte, productLowByte}, 16'hfe01);
    cfg(4'h3, 1'b0);
    op(16'h0345, 21'h0, 8'h02, 8'h03);
    cmp(fileAddr, 12'h345);
    op(16'h0290, 21'h0, 8'h02, 8'h03);
    cmp(fileAddr, 12'hf90);
    cfg(4'h3, 1'b1);
    op(16'h025f, 21'h0, 8'h02, 8'h03);
    cmp(indexedMode, 1'b1);
    op(16'h0260, 21'h0, 8'h02, 8'h03);
    cmp(indexedMode, 1'b0);
    op(16'h035f, 21'h0, 8'h02, 8'h03);
    cmp(indexedMode, 1'b0);
    cfg(4'h0, 1'b0);
    foreach (negIn[i]) begin
      d = negIn[i];
      r = ~d + 8'h01;
      op(16'h6d10, 21'h0, 8'h00, d);
      cmp({fileWrEn, fileWrData}, {1'b1, r});
      cmp({flagsWrEn, flagsOut}, {1'b1, r[7], d == 8'h80, r == 8'h00, d[3:0] == 4'h0, d == 8'h00});
    end
    op(mns_pkg::OP_PUSH, 21'h000124, 8'h00, 8'h00);
    op(mns_pkg::OP_PUSH, 21'h000200, 8'h00, 8'h00);
    tick();
    cmp({stackDepth, stackTopEntry}, {5'h02, 21'h000202});
    op(mns_pkg::OP_POP, 21'h000300, 8'h00, 8'h00);
    tick();
    cmp({stackDepth, stackTopEntry}, {5'h01, 21'h000126});
    foreach (callOff[i]) begin
      op({mns_pkg::OP_RELATIVE_SUBROUTINE_CALL_HI5, callOff[i]}, 21'h001000, 8'h00, 8'h00);
      cmp({pcLoad, fetchStall, pcTarget}, {2'b11, callJump[i]});
      tick();
      cmp(stackTopEntry, 21'h001002);
    end
    // Multiply offered in the bubble must leave the product alone
    put({mns_pkg::OP_RELATIVE_SUBROUTINE_CALL_HI5, 11'h000}, 21'h002000, 8'h11, 8'h11);
    put(16'h03b5, 21'h002002, 8'h11, 8'h11);
    done();
    cmp({pcLoad, productHighByte, productLowByte}, 17'h00006);
    cmp(stackTopEntry, 21'h002002);
    op(mns_pkg::OP_IDLE, 21'h0, 8'h00, 8'h00);
    cmp({idleOp, pcLoad, fileWrEn}, 3'b100);
    op(16'hf123, 21'h0, 8'h00, 8'h00);
    cmp({idleOp, pcLoad, fileWrEn}, 3'b100);
    op(mns_pkg::OP_SWRESET, 21'h000040, 8'h00, 8'h00);
    cmp({softResetPulse, pcLoad, flagsWrEn, pcTarget}, {3'b111, 21'h0});
    cmp({productHighByte, productLowByte, flagsOut}, 21'h0);
    tick();
    cmp(stackDepth, 5'h00);
    // Enable low must freeze the product pair
    op(16'h03b5, 21'h0, 8'hc4, 8'hb5);
    @(posedge clock);
    clockEnable <= 1'b0;
    op(16'h02ff, 21'h0, 8'hff, 8'hff);
    cmp({productHighByte, productLowByte}, 16'h8a94);
    @(posedge clock);
    clockEnable <= 1'b1;
    // Pin reset clears the same state as the software reset
    @(posedge clock);
    masterClearPinN <= 1'b0;
    @(posedge clock);
    masterClearPinN <= 1'b1;
    #1;
    cmp({pcLoad, flagsWrEn, productHighByte, productLowByte}, 18'h30000);
    wrap_up();
  end

  // Whole sequence needs under a hundred cycles
  initial begin
    #20000;
    errors++;
    wrap_up();
  end
endmodule : mns_core_exec_test
`default_nettype wire

// File: verilog/mns_addr_gen.sv
`timescale 1ns/1ns
`default_nettype none
module mns_addr_gen (
  input  wire logic [7:0]  fileAddr,
  input  wire logic        accessBit,
  input  wire logic [3:0]  bankSelectReg,
  input  wire logic        extEnable,
  input  wire logic [7:0]  indexBase,
  output var  logic [11:0] dataAddr,
  output var  logic        indexedMode
);
  // ----------------------------------------
  // Bank and indexed address select
  // ----------------------------------------
  logic [11:0] accessAddr;
  logic [11:0] bankAddr;
  logic [11:0] idxAddr;
  assign indexedMode = extEnable && !accessBit && (fileAddr <= mns_pkg::IDX_LIMIT);
  assign accessAddr  = ({4'h0, fileAddr} < mns_pkg::ACCESS_SPLIT) ? {4'h0, fileAddr}
                       : (mns_pkg::ACCESS_HIGH | {4'h0, fileAddr});
  assign bankAddr    = {bankSelectReg, fileAddr};
  assign idxAddr     = {4'h0, indexBase} + {4'h0, fileAddr};
  always_comb begin
    if (indexedMode) begin
      dataAddr = idxAddr;
    end else if (accessBit) begin
      dataAddr = bankAddr;
    end else begin
      dataAddr = accessAddr;
    end
  end
endmodule : mns_addr_gen
`default_nettype wire

// File: verilog/mns_core_exec.sv
`timescale 1ns/1ns
`default_nettype none
module mns_core_exec (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        clockEnable,
  input  wire logic        masterClearPinN,
  input  wire logic        instrValid,
  input  wire logic [15:0] instrWord,
  input  wire logic [20:0] fetchPc,
  input  wire logic [7:0]  accIn,
  input  wire logic [4:0]  flagsIn,
  input  wire logic [3:0]  bankSelectReg,
  input  wire logic        extEnable,
  input  wire logic [7:0]  indexBase,
  input  wire logic [7:0]  fileRdData,
  output var  logic [11:0] fileAddr,
  output var  logic        fileWrEn,
  output var  logic [7:0]  fileWrData,
  output var  logic        indexedMode,
  output var  logic [7:0]  productHighByte,
  output var  logic [7:0]  productLowByte,
  output var  logic [4:0]  flagsOut,
  output var  logic        flagsWrEn,
  output var  logic        pcLoad,
  output var  logic [20:0] pcTarget,
  output var  logic [20:0] stackTopEntry,
  output var  logic [4:0]  stackDepth,
  output var  logic        fetchStall,
  output var  logic        softResetPulse,
  output var  logic        idleOp
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  mns_pkg::mns_state_t stateQ;
  mns_pkg::mns_state_t stateD;
  logic        runSlot;
  logic        isMul;
  logic        isNeg;
  logic        isPop;
  logic        isPush;
  logic        isRcall;
  logic        isReset;
  logic        isIdle;
  logic        prevTwoWordQ;
  logic        twoWordFirst;
  assign runSlot = clockEnable && instrValid && (stateQ == mns_pkg::MNS_RUN);
  assign isMul   = runSlot && (instrWord[15:9] == mns_pkg::OP_MUL_HI7);
  assign isNeg   = runSlot && (instrWord[15:9] == mns_pkg::OP_NEG_HI7);
  assign isPop   = runSlot && (instrWord == mns_pkg::OP_POP);
  assign isPush  = runSlot && (instrWord == mns_pkg::OP_PUSH);
  assign isRcall = runSlot && (instrWord[15:11] == mns_pkg::OP_RELATIVE_SUBROUTINE_CALL_HI5);
  assign isReset = runSlot && (instrWord == mns_pkg::OP_SWRESET);
  assign isIdle  = runSlot && ((instrWord == mns_pkg::OP_IDLE)
                   || ((instrWord[15:12] == mns_pkg::OP_SECOND_HI) && !prevTwoWordQ));
  // First word of a two-word form; its follower is the operand, not an idle_op
  assign twoWordFirst = runSlot && (instrWord[15:12] == 4'hc);

  // ----------------------------------------
  // Operand address
  // ----------------------------------------
  logic [11:0] addrW;
  logic        idxW;
  mns_addr_gen uAddr (
    .fileAddr      (instrWord[7:0]),
    .accessBit     (instrWord[mns_pkg::ACC_BIT]),
    .bankSelectReg (bankSelectReg),
    .extEnable     (extEnable),
    .indexBase     (indexBase),
    .dataAddr      (addrW),
    .indexedMode   (idxW)
  );

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  logic [15:0] product;
  logic [7:0]  negResult;
  logic [8:0]  negSum;
  logic [4:0]  negSumLo;
  logic [4:0]  negFlags;
  logic [20:0] retAddr;
  logic [20:0] relTarget;
  logic [20:0] offsetX2;
  // Operands are unsigned, so no overflow or carry can arise
  assign product   = {8'h00, accIn} * {8'h00, fileRdData};
  assign negSum    = {1'b0, ~fileRdData} + 9'h001;
  assign negResult = negSum[7:0];
  assign negSumLo  = {1'b0, ~fileRdData[3:0]} + 5'h01;
  always_comb begin
    negFlags                    = flagsIn;
    negFlags[mns_pkg::FLAG_C]   = negSum[8];
    negFlags[mns_pkg::FLAG_DC]  = negSumLo[4];
    negFlags[mns_pkg::FLAG_Z]   = (negResult == 8'h00);
    negFlags[mns_pkg::FLAG_N]   = negResult[7];
    negFlags[mns_pkg::FLAG_OV]  = (fileRdData == 8'h80);
  end
  assign retAddr   = fetchPc + mns_pkg::PC_STEP;
  assign offsetX2  = {{9{instrWord[10]}}, instrWord[10:0], 1'b0};
  assign relTarget = retAddr + offsetX2;

  // ----------------------------------------
  // Return stack
  // ----------------------------------------
  logic [20:0] stackQ [mns_pkg::STACK_DEPTH];
  logic [4:0]  depthQ;
  logic        doPush;
  logic        doPop;
  logic        anyReset;
  assign doPush   = isPush || isRcall;
  assign doPop    = isPop && (depthQ != 5'h00);
  // Pin reset and software reset share one path, so both clear the same state
  assign anyReset = clockEnable && (!masterClearPinN || isReset);
  genvar gi;
  generate
    for (gi = 0; gi < mns_pkg::STACK_DEPTH; gi++) begin : gStack
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          stackQ[gi] <= mns_pkg::PC_RESET;
        end else if (anyReset) begin
          stackQ[gi] <= mns_pkg::PC_RESET;
        end else if (doPush) begin
          if (gi == 0) begin
            stackQ[gi] <= (isRcall ? retAddr : retAddr);
          end else begin
            stackQ[gi] <= stackQ[gi-1];
          end
        end else if (doPop) begin
          if (gi == mns_pkg::STACK_DEPTH - 1) begin
            stackQ[gi] <= mns_pkg::PC_RESET;
          end else begin
            stackQ[gi] <= stackQ[gi+1];
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      depthQ <= 5'h00;
    end else if (anyReset) begin
      depthQ <= 5'h00;
    end else if (doPush && depthQ != 5'(mns_pkg::STACK_DEPTH)) begin
      depthQ <= depthQ + 5'h01;
    end else if (doPop) begin
      depthQ <= depthQ - 5'h01;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      mns_pkg::MNS_RUN: begin
        if (isRcall) begin
          stateD = mns_pkg::MNS_BUBBLE;
        end
      end
      mns_pkg::MNS_BUBBLE: begin
        stateD = mns_pkg::MNS_RUN;
      end
      default: begin
        stateD = mns_pkg::MNS_RUN;
      end
    endcase
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stateQ       <= mns_pkg::MNS_RUN;
      prevTwoWordQ <= 1'b0;
    end else if (anyReset) begin
      stateQ       <= mns_pkg::MNS_RUN;
      prevTwoWordQ <= 1'b0;
    end else if (clockEnable) begin
      stateQ <= stateD;
      if (runSlot) begin
        prevTwoWordQ <= twoWordFirst;
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      productHighByte <= mns_pkg::BYTE_RESET;
      productLowByte  <= mns_pkg::BYTE_RESET;
    end else if (anyReset) begin
      productHighByte <= mns_pkg::BYTE_RESET;
      productLowByte  <= mns_pkg::BYTE_RESET;
    end else if (isMul) begin
      productHighByte <= product[15:8];
      productLowByte  <= product[7:0];
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fileAddr    <= 12'h000;
      fileWrEn    <= 1'b0;
      fileWrData  <= mns_pkg::BYTE_RESET;
      indexedMode <= 1'b0;
      flagsOut    <= mns_pkg::FLAGS_RESET;
      flagsWrEn   <= 1'b0;
    end else if (anyReset) begin
      fileWrEn    <= 1'b0;
      flagsOut    <= mns_pkg::FLAGS_RESET;
      flagsWrEn   <= 1'b1;
    end else if (clockEnable) begin
      fileAddr    <= addrW;
      indexedMode <= (isMul || isNeg) && idxW;
      fileWrEn    <= isNeg;
      fileWrData  <= negResult;
      flagsOut    <= negFlags;
      flagsWrEn   <= isNeg;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pcLoad         <= 1'b0;
      pcTarget       <= mns_pkg::PC_RESET;
      fetchStall     <= 1'b0;
      softResetPulse <= 1'b0;
      idleOp         <= 1'b0;
      stackTopEntry  <= mns_pkg::PC_RESET;
      stackDepth     <= 5'h00;
    end else if (clockEnable) begin
      pcLoad         <= isRcall || anyReset;
      pcTarget       <= anyReset ? mns_pkg::PC_RESET : relTarget;
      fetchStall     <= isRcall;
      softResetPulse <= isReset;
      idleOp         <= isIdle && !anyReset;
      stackTopEntry  <= stackQ[0];
      stackDepth     <= depthQ;
    end
  end
endmodule : mns_core_exec
`default_nettype wire

// File: verilog/mns_pkg.sv
package mns_pkg;
  // ----------------------------------------
  // Opcode patterns
  // ----------------------------------------
  localparam logic [6:0]  OP_MUL_HI7   = 7'h01;    // 0000 001a
  localparam logic [6:0]  OP_NEG_HI7   = 7'h36;    // 0110 110a
  localparam logic [4:0]  OP_RELATIVE_SUBROUTINE_CALL_HI5 = 5'h1b;    // 1101 1nnn
  localparam logic [15:0] OP_POP       = 16'h0006;
  localparam logic [15:0] OP_PUSH      = 16'h0005;
  localparam logic [15:0] OP_SWRESET   = 16'h00ff;
  localparam logic [15:0] OP_IDLE      = 16'h0000;
  localparam logic [3:0]  OP_SECOND_HI = 4'hf;
  // ----------------------------------------
  // Field positions and limits
  // ----------------------------------------
  localparam int          ACC_BIT      = 8;
  localparam logic [7:0]  IDX_LIMIT    = 8'h5f;    // 95
  localparam logic [11:0] ACCESS_SPLIT = 12'h080;
  localparam logic [11:0] ACCESS_HIGH  = 12'hf00;
  localparam int          STACK_DEPTH  = 31;
  localparam int          PC_W         = 21;
  localparam logic [20:0] PC_STEP      = 21'h000002;
  localparam logic [20:0] PC_RESET     = 21'h000000;
  // ----------------------------------------
  // Status flag bit positions
  // ----------------------------------------
  localparam int          FLAG_C       = 0;
  localparam int          FLAG_DC      = 1;
  localparam int          FLAG_Z       = 2;
  localparam int          FLAG_OV      = 3;
  localparam int          FLAG_N       = 4;
  localparam logic [4:0]  FLAGS_RESET  = 5'h00;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [3:0]  BANK_RESET   = 4'h0;
  // ----------------------------------------
  // Execution states
  // ----------------------------------------
  typedef enum logic [1:0] {
    MNS_RUN    = 2'b00,
    MNS_BUBBLE = 2'b01
  } mns_state_t;
endpackage : mns_pkg
